/* hw/ish_pkg.sv */
// package: register map, field positions, hard-map table for debug status
package ish_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_CTRL = 4'h1;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h2;
	localparam logic [3:0] OFF_IRQ_CLR = 4'h3;
	localparam logic [3:0] OFF_IRQ_EN = 4'h4;
	localparam int BIT_EMU_EN = 3;
	localparam int BIT_BUS_FLAG = 2;
	localparam int BIT_PROG_FLAG = 1;
	localparam int BIT_PIN_FLAG = 0;
	localparam int CTRL_IRQ_EN = 4;
	localparam int CTRL_HM_DIS = 3;
	localparam int CTRL_SINGLE = 2;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] HM_HIGH = 16'hFFFC;
	localparam logic [15:0] HM_WORD6 = 16'h0020;
	localparam logic [15:0] HM_VEC_LO = 16'h0010;
	localparam logic [31:0] HM_A0 = 32'h0000_0000;
	localparam logic [31:0] HM_A2 = 32'h0000_0002;
	localparam logic [31:0] HM_A4 = 32'h0000_0004;
	localparam logic [31:0] HM_A6 = 32'h0000_0006;
	localparam logic [31:0] HM_A28 = 32'h0000_0028;
	localparam logic [31:0] HM_A2A = 32'h0000_002A;
	localparam logic [15:0] MON_REGION = 16'hFFFC;
	localparam logic [31:0] BRK_MASK_RESET = 32'hFFFF_FFFF;
endpackage

/* hw/ish_evt_if.sv */
// interface: event strobes and flag state between top and flag module
interface ish_evt_if;
	logic bus_hit;
	logic prog_hit;
	logic pin_fall;
	logic [2:0] clr;
	logic [2:0] flags;
	modport top (output bus_hit, prog_hit, pin_fall, clr, input flags);
	modport flg (input bus_hit, prog_hit, pin_fall, clr, output flags);
endinterface

/* hw/ish_flags.sv */
// module: three sticky event flags with write-one-to-clear
module ish_flags (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	ish_evt_if.flg ev
);
	import ish_pkg::*;
	logic [2:0] flag;
	logic [2:0] set_v;
	assign set_v = {ev.bus_hit, ev.prog_hit, ev.pin_fall};
	assign ev.flags = flag;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			flag <= 3'h0;
		end else begin
			flag <= (flag & ~ev.clr) | set_v;
		end
	end
	chk_set_wins: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		ev.bus_hit |=> flag[2])
		else $error("bus flag lost");
	chk_clear_one: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(ev.clr[1] && !ev.prog_hit) |=> !flag[1])
		else $error("program flag not cleared");
	chk_flag_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(flag[0] && !ev.clr[0]) |=> flag[0])
		else $error("pin flag dropped");
endmodule

/* hw/ish_pinsync.sv */
// module: two-stage synchroniser with falling-edge detect
module ish_pinsync (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic fall_o
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end
	assign level_o = s2;
	assign fall_o = s3 & ~s2;
	chk_fall_edge: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		fall_o |-> ($past(s2) && !s2))
		else $error("false falling edge");
endmodule

/* hw/ish_top.sv */
// module: emulation status, hard-map read overlay, monitor select, breaks
module ish_top (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [ish_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [ish_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [ish_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic [31:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic [15:0] ext_rdata_i,
	input wire logic vec_fetch_i,
	input wire logic emulator_interrupt_pin_n_i,
	input wire logic breakpoint_pin_i,
	output logic breakpoint_pin_o,
	output logic breakpoint_pin_oe_n_o,
	output logic [15:0] cpu_rdata_o,
	output logic hard_map_hit_o,
	output logic monitor_chip_select_n_o,
	output logic level7_irq_o,
	output logic irq_o
);
	import ish_pkg::*;
	ish_evt_if ev ();
	logic emulation_mode_enable;
	logic [15:0] ctrl;
	logic [31:0] brk_addr;
	logic [31:0] brk_mask;
	logic [2:0] irq_stat;
	logic [2:0] irq_en;
	logic bp_s1;
	logic bp_s2;
	logic pin_level;
	logic pin_fall;
	wire [2:0] flags = ev.flags;
	wire wr_status = reg_wr_i && reg_addr_i == OFF_STATUS;
	wire wr_ctrl = reg_wr_i && reg_addr_i == OFF_CTRL;
	wire wr_addr_lo = reg_wr_i && reg_addr_i == 4'h5;
	wire wr_addr_hi = reg_wr_i && reg_addr_i == 4'h6;
	wire wr_mask_lo = reg_wr_i && reg_addr_i == 4'h7;
	wire wr_mask_hi = reg_wr_i && reg_addr_i == 4'h8;
	wire wr_iclr = reg_wr_i && reg_addr_i == OFF_IRQ_CLR;
	wire wr_ien = reg_wr_i && reg_addr_i == OFF_IRQ_EN;
	wire hm_dis = ctrl[CTRL_HM_DIS];
	wire single_break_select = ctrl[CTRL_SINGLE];
	wire bus_break_irq_enable = ctrl[CTRL_IRQ_EN];
	wire cpu_acc = cpu_rd_i || cpu_wr_i;
	wire hi_match = ((cpu_addr_i ^ brk_addr) & ~brk_mask) == 32'h0;
	// in multi mode the synchronised input pin completes the low half
	wire bus_hit = cpu_acc && emulation_mode_enable && hi_match
		&& (single_break_select || !bp_s2);
	// hard-map only in emulation, reads only
	wire hm_on = emulation_mode_enable && !hm_dis && cpu_rd_i;
	wire hm_hi = cpu_addr_i == HM_A0 || cpu_addr_i == HM_A2
		|| cpu_addr_i == HM_A4 || cpu_addr_i == HM_A28;
	wire hm_6 = cpu_addr_i == HM_A6;
	wire hm_lo = cpu_addr_i == HM_A2A;
	wire hm_sel = hm_on && (hm_hi || hm_6 || hm_lo);
	wire [15:0] hm_val = hm_hi ? HM_HIGH : (hm_6 ? HM_WORD6 : HM_VEC_LO);
	wire [15:0] next_cpu_rdata = hm_sel ? hm_val : ext_rdata_i;
	wire mon_hit = cpu_acc && cpu_addr_i[31:16] == MON_REGION;
	wire [2:0] next_irq_stat = (irq_stat & ~(wr_iclr ? reg_wdata_i[2:0] : 3'h0))
		| {bus_hit, vec_fetch_i, pin_fall};
	wire [15:0] status_view = {12'h000, emulation_mode_enable, flags};
	wire [15:0] next_rdata =
		reg_addr_i == OFF_STATUS ? status_view :
		reg_addr_i == OFF_CTRL ? ctrl :
		reg_addr_i == OFF_IRQ_STAT ? {13'h0000, irq_stat} :
		reg_addr_i == OFF_IRQ_EN ? {13'h0000, irq_en} :
		reg_addr_i == 4'h5 ? brk_addr[15:0] :
		reg_addr_i == 4'h6 ? brk_addr[31:16] :
		reg_addr_i == 4'h7 ? brk_mask[15:0] :
		reg_addr_i == 4'h8 ? brk_mask[31:16] : 16'h0000;

	assign ev.bus_hit = bus_hit;
	// line vector fetch is program break
	assign ev.prog_hit = vec_fetch_i;
	assign ev.pin_fall = pin_fall;
	assign ev.clr = wr_status ? reg_wdata_i[2:0] : 3'h0;

	ish_flags u_flags (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.ev(ev)
	);
	ish_pinsync u_pin (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.pin_i(emulator_interrupt_pin_n_i),
		.level_o(pin_level),
		.fall_o(pin_fall)
	);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			bp_s1 <= 1'b1;
			bp_s2 <= 1'b1;
		end else begin
			bp_s1 <= breakpoint_pin_i;
			bp_s2 <= bp_s1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			emulation_mode_enable <= STATUS_RESET[BIT_EMU_EN];
		end else if (wr_status) begin
			emulation_mode_enable <= reg_wdata_i[BIT_EMU_EN];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl <= CTRL_RESET;
			brk_addr <= 32'h0000_0000;
			brk_mask <= BRK_MASK_RESET;
			irq_en <= 3'h0;
		end else begin
			if (wr_ctrl) ctrl <= {11'h000, reg_wdata_i[4:2], 2'h0};
			if (wr_addr_lo) brk_addr[15:0] <= reg_wdata_i;
			if (wr_addr_hi) brk_addr[31:16] <= reg_wdata_i;
			if (wr_mask_lo) brk_mask[15:0] <= reg_wdata_i;
			if (wr_mask_hi) brk_mask[31:16] <= reg_wdata_i;
			if (wr_ien) irq_en <= reg_wdata_i[2:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 16'h0000;
			cpu_rdata_o <= 16'h0000;
			hard_map_hit_o <= 1'b0;
			monitor_chip_select_n_o <= 1'b1;
			level7_irq_o <= 1'b0;
			irq_o <= 1'b0;
			breakpoint_pin_o <= 1'b1;
			breakpoint_pin_oe_n_o <= 1'b1;
		end else begin
			reg_rdata_o <= reg_rd_i ? next_rdata : 16'h0000;
			cpu_rdata_o <= next_cpu_rdata;
			hard_map_hit_o <= hm_sel;
			monitor_chip_select_n_o <= !mon_hit;
			// level 7 follows enable and flag
			level7_irq_o <= bus_break_irq_enable && flags[BIT_BUS_FLAG];
			irq_o <= |(next_irq_stat & irq_en);
			// drive low on internal hit in single mode
			breakpoint_pin_o <= !(single_break_select && bus_hit);
			breakpoint_pin_oe_n_o <= !single_break_select;
		end
	end

	chk_hm_word: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(hm_on && hm_6) |=> (cpu_rdata_o == 16'h0020 && hard_map_hit_o))
		else $error("hard-map word 6 wrong");
	chk_hm_vec: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(hm_on && cpu_addr_i == 32'h2A) |=> cpu_rdata_o == 16'h0010)
		else $error("vector word wrong");
	chk_hm_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(!cpu_rd_i || hm_dis || !emulation_mode_enable) |=> !hard_map_hit_o)
		else $error("hard-map outside emulation read");
	chk_mon_cs: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(cpu_acc && cpu_addr_i[31:16] == 16'hFFFC) |=> !monitor_chip_select_n_o)
		else $error("monitor select missing");
	chk_l7_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!bus_break_irq_enable |=> !level7_irq_o)
		else $error("level 7 without enable");
	chk_mode_bit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		wr_status |=> emulation_mode_enable == $past(reg_wdata_i[3]))
		else $error("mode bit not stored");
	chk_pin_dir: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!single_break_select |=> breakpoint_pin_oe_n_o)
		else $error("pin driven in multi mode");
	// bus hit reaches status one cycle on
	chk_bus_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		bus_hit |=> flags[2])
		else $error("bus flag not set");
	chk_rst_zero: assert property (@(posedge sys_clk_i)
		srst_i |=> (flags == 3'h0 && !emulation_mode_enable))
		else $error("reset not clean");
	chk_pin_low: assert property (@(posedge sys_clk_i)
		disable iff (srst_i) pin_fall |-> !pin_level)
		else $error("edge seen with pin high");
endmodule

/* test/ish_partner.sv */
// partner: external memory, emulator controller and comparator
module ish_partner (
	input wire logic sys_clk_i,
	input wire logic [31:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic breakpoint_pin_o_i,
	input wire logic breakpoint_pin_oe_n_i,
	output logic [15:0] ext_rdata_o,
	output logic emulator_interrupt_pin_n_o,
	output logic breakpoint_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog = 1'b0;
	logic ext_match_n;
	always_ff @(posedge sys_clk_i) begin
		tog <= ~tog;
	end
	// released bus toggles so stale data never passes for a match
	assign ext_rdata_o = cpu_rd_i ? ~cpu_addr_i[15:0] : {16{tog}};
	assign ext_match_n = !(cpu_rd_i && cpu_addr_i[15:0] == 16'h0100);
	assign breakpoint_pin_o = breakpoint_pin_oe_n_i ? ext_match_n
		: breakpoint_pin_o_i;
	initial emulator_interrupt_pin_n_o = 1'b1;
	// request by pulling the pin low
	task automatic fall();
		@(posedge sys_clk_i) emulator_interrupt_pin_n_o <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		emulator_interrupt_pin_n_o <= 1'b1;
	endtask
endmodule

/* test/ice_status_hardmap_bench.sv */
// bench: register, hard-map, monitor select, flag and irq tests
module ice_status_hardmap_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ish_pkg::*;
	logic clk = 0, srst = 1, wr = 0, rd = 0, crd = 0, cwr = 0, vec = 0;
	logic [3:0] a = 0;
	logic [15:0] wd = 0, rdat, crdat, ext;
	logic [31:0] ca = 0;
	logic pin_n, bpi, bpo, oe_n, hit, cs_n, l7, irq;
	int mismatches = 0, total_checks = 0, cyc = 0;
	logic [31:0] ra [7] = '{0, 2, 4, 6, 'h28, 'h2A, 8};
	logic [15:0] rv [7] = '{'hFFFC, 'hFFFC, 'hFFFC, 'h0020, 'hFFFC,
		'h0010, 'hFFF7};
	ish_top ish_top_inst (.sys_clk_i(clk), .srst_i(srst), .reg_addr_i(a),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
		.cpu_addr_i(ca), .cpu_rd_i(crd), .cpu_wr_i(cwr), .ext_rdata_i(ext),
		.vec_fetch_i(vec), .emulator_interrupt_pin_n_i(pin_n),
		.breakpoint_pin_i(bpi), .breakpoint_pin_o(bpo),
		.breakpoint_pin_oe_n_o(oe_n), .cpu_rdata_o(crdat),
		.hard_map_hit_o(hit), .monitor_chip_select_n_o(cs_n),
		.level7_irq_o(l7), .irq_o(irq));
	ish_partner ish_partner_inst (.sys_clk_i(clk), .cpu_addr_i(ca),
		.cpu_rd_i(crd), .breakpoint_pin_o_i(bpo),
		.breakpoint_pin_oe_n_i(oe_n), .ext_rdata_o(ext),
		.emulator_interrupt_pin_n_o(pin_n), .breakpoint_pin_o(bpi));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(logic [3:0] ad, logic [15:0] d);
		@(posedge clk) {a, wd, wr} <= {ad, d, 1'b1};
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rreg(logic [3:0] ad, logic [15:0] e);
		@(posedge clk) {a, rd} <= {ad, 1'b1};
		@(posedge clk) rd <= 1'b0;
		#1 chk("reg_rdata", e, rdat);
	endtask
	// rw high reads, low writes; outputs land one cycle on
	task automatic cpu(logic [31:0] ad, logic rw);
		@(posedge clk) {ca, crd, cwr} <= {ad, rw, !rw};
		@(posedge clk) {crd, cwr} <= 2'b00;
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rreg(OFF_STATUS, 0);
		chk("cs_oe", 2'b11, {cs_n, oe_n});
		wreg(OFF_STATUS, 'h8);
		rreg(OFF_STATUS, 'h8);
		for (int i = 0; i < 7; i++) begin
			cpu(ra[i], 1'b1);
			chk("cpu_rdata", rv[i], crdat);
		end
		cpu('hFFFC0010, 1'b1);
		chk("cs_n", 0, cs_n);
		cpu('h00100000, 1'b1);
		chk("cs_n", 1, cs_n);
		$display("hard map test done");
		wreg(OFF_CTRL, 'h8);
		cpu(0, 1'b1);
		chk("cpu_rdata", 'hFFFF, crdat);
		wreg(OFF_CTRL, 0);
		cpu(0, 1'b0);
		chk("hard_map_hit", 0, hit);
		wreg(OFF_IRQ_EN, 'h2);
		@(posedge clk) vec <= 1'b1;
		@(posedge clk) vec <= 1'b0;
		rreg(OFF_STATUS, 'hA);
		chk("irq", 1, irq);
		wreg(OFF_IRQ_CLR, 'h7);
		#1 chk("irq", 0, irq);
		wreg(OFF_STATUS, 'h8);
		rreg(OFF_STATUS, 'hA);
		wreg(OFF_STATUS, 'hA);
		rreg(OFF_STATUS, 'h8);
		@(posedge clk) {a, wd, wr, vec} <= {4'h0, 16'hA, 2'b11};
		@(posedge clk) {wr, vec} <= 2'b00;
		rreg(OFF_STATUS, 'hA);
		wreg(OFF_IRQ_CLR, 'h7);
		rreg(OFF_IRQ_STAT, 0);
		ish_partner_inst.fall();
		rreg(OFF_STATUS, 'hB);
		rreg(OFF_IRQ_STAT, 'h1);
		chk("irq_masked", 0, irq);
		$display("flag test done");
		wreg(OFF_CTRL, 'h14);
		@(posedge clk);
		#1 chk("oe_n", 0, oe_n);
		cpu('h200, 1'b1);
		chk("bp_pin", 0, bpo);
		rreg(OFF_STATUS, 'hF);
		chk("level7", 1, l7);
		wreg(OFF_STATUS, 'hF);
		rreg(OFF_STATUS, 'h8);
		chk("level7", 0, l7);
		wreg(OFF_CTRL, 'h10);
		// read held long enough for the synced external match to meet it
		@(posedge clk) {ca, crd} <= {32'h0000_0100, 1'b1};
		repeat (3) @(posedge clk);
		crd <= 1'b0;
		rreg(OFF_STATUS, 'hC);
		rreg(4'hF, 0);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		rreg(OFF_STATUS, 0);
		$display("break and reset test done");
		results();
	end
endmodule
